// File: hw/rcf_sync3.sv
/*
 * Three-stage synchroniser with agreement filter for an asynchronous pin.
 * Assumes the pin is slow compared with the clock; output moves only when
 * stages two and three agree.
 */
`timescale 1ns/1ps
module rcf_sync3 #(
	parameter logic RST_VAL = 1'h1
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// Pin side
	input  wire logic i_pin,
	// Clock domain side
	output logic      o_level
);
	import rcf_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
	} rcf_sync_state_s;

	rcf_sync_state_s st_reg;
	rcf_sync_state_s st_next;

	always_comb begin
		st_next    = st_reg;
		// First stage feeds only the second
		st_next.s1 = i_pin;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		if (st_reg.s2 == st_reg.s3) begin
			st_next.lvl = st_reg.s3;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg <= {4{RST_VAL}};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_level = st_reg.lvl;

endmodule

// File: hw/rcf_top.sv
/*
 * Row boundary clock generator and overflow / end-of-message interrupt logic.
 * Assumes the sequencer supplies operation start/stop, the end-of-array level
 * and the marker bits of the current row; the command decoder supplies a
 * one-cycle read-status pulse. Slave select arrives straight from its pin.
 */
//////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1 - Row clock period equals one memory row
// R2 - Normal rows: 175 ms high, 25 ms low
// R3 - Cueing rows: 109.37 us high, 15.63 us low
// R4 - Record start adds one low interval of extra high time
// R5 - Overflow or marker pulls interrupt low, held
// R6 - Every flagged termination raises the interrupt
// R7 - Next SPI cycle start releases the interrupt
// R8 - Read-status instruction reports interrupt flags
// R9 - Overflow flag at end of memory array
// R10 - End-of-message flag only during playback markers
// R11 - Eight marker positions within each row
//////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module rcf_top
	import rcf_pkg::*;
#(
	parameter int unsigned P_ROW_HIGH_CYC = RCF_ROW_HIGH_CYC,
	parameter int unsigned P_ROW_LOW_CYC  = RCF_ROW_LOW_CYC,
	parameter int unsigned P_CUE_HIGH_CYC = RCF_CUE_HIGH_CYC,
	parameter int unsigned P_CUE_LOW_CYC  = RCF_CUE_LOW_CYC
) (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_arst_n,
	// Sequencer
	input  wire rcf_pkg::rcf_op_s     i_op,
	input  wire logic                 i_mem_end,
	input  wire rcf_pkg::rcf_marks_t  i_row_eom_marks,
	// Serial interface
	input  wire logic                 i_ss_n,
	input  wire logic                 i_read_interrupt_status_cmd,
	// Open-drain pins
	output logic                      o_row_boundary_clock_o,
	output logic                      o_row_boundary_clock_oe,
	output logic                      o_int_o,
	output logic                      o_int_oe,
	// Status
	output rcf_pkg::rcf_status_s      o_status,
	output logic                      o_op_done,
	output logic                      o_row_adv,
	output logic                      o_busy
);
	import rcf_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Limits
	localparam rcf_cnt_t ROW_HI_L  = rcf_cnt_t'(P_ROW_HIGH_CYC - 1);
	localparam rcf_cnt_t ROW_LO_L  = rcf_cnt_t'(P_ROW_LOW_CYC - 1);
	localparam rcf_cnt_t CUE_HI_L  = rcf_cnt_t'(P_CUE_HIGH_CYC - 1);
	localparam rcf_cnt_t CUE_LO_L  = rcf_cnt_t'(P_CUE_LOW_CYC - 1);
	localparam rcf_cnt_t ROW_SEG_L =
		rcf_cnt_t'((P_ROW_HIGH_CYC + P_ROW_LOW_CYC) / RCF_EOM_SLOTS - 1);
	localparam rcf_cnt_t CUE_SEG_L =
		rcf_cnt_t'((P_CUE_HIGH_CYC + P_CUE_LOW_CYC) / RCF_EOM_SLOTS - 1);
	localparam rcf_cnt_t CNT_ONE   = rcf_cnt_t'(1);

	typedef struct packed {
		rcf_rac_e    fsm;
		rcf_mode_e   mode;
		rcf_cnt_t    ph_cnt;
		rcf_cnt_t    seg_cnt;
		rcf_slot_t   seg_idx;
		logic        ovf;
		logic        end_of_message_flag;
		logic        int_pend;
		logic        rac_o;
		logic        rac_oe;
		logic        int_o;
		logic        int_oe;
		rcf_status_s status;
		logic        op_done;
		logic        row_adv;
		logic        busy;
		logic        ss_prev;
	} rcf_top_state_s;

	rcf_top_state_s st_reg;
	rcf_top_state_s st_next;

	logic     ss_level;
	logic     ss_fall;
	logic     hit_ovf;
	logic     hit_eom;
	rcf_cnt_t hi_lim;
	rcf_cnt_t lo_lim;
	rcf_cnt_t seg_lim;

	////////////////////////////////////////////////////////////////////////////////
	// Slave select pin
	rcf_sync3 #(
		.RST_VAL (RCF_SS_IDLE)
	) u_ss_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_pin    (i_ss_n),
		.o_level  (ss_level)
	);

	assign ss_fall = st_reg.ss_prev & ~ss_level;

	// Cueing runs the same row at a much shorter period
	assign hi_lim  = (st_reg.mode == RCF_MODE_CUE) ? CUE_HI_L : ROW_HI_L;   // R2 R3
	assign lo_lim  = (st_reg.mode == RCF_MODE_CUE) ? CUE_LO_L : ROW_LO_L;   // R2 R3
	assign seg_lim = (st_reg.mode == RCF_MODE_CUE) ? CUE_SEG_L : ROW_SEG_L; // R11

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		st_next              = st_reg;
		st_next.op_done      = 1'h0;
		st_next.row_adv      = 1'h0;
		st_next.status.valid = 1'h0;
		st_next.ss_prev      = ss_level;
		hit_ovf              = 1'h0;
		hit_eom              = 1'h0;

		case (st_reg.fsm)
			RCF_ST_IDLE: begin
				if (i_op.start) begin
					st_next.mode    = i_op.mode;
					st_next.ph_cnt  = '0;
					st_next.seg_cnt = '0;
					st_next.seg_idx = '0;
					// Sample-and-hold loading delays the first record row
					st_next.fsm = (i_op.mode == RCF_MODE_REC) ? RCF_ST_LOAD : RCF_ST_HIGH; // R4
				end
			end
			RCF_ST_LOAD: begin
				st_next.ph_cnt = st_reg.ph_cnt + CNT_ONE;
				if (st_reg.ph_cnt == lo_lim) begin
					st_next.ph_cnt = '0;
					st_next.fsm    = RCF_ST_HIGH; // R4
				end
			end
			RCF_ST_HIGH: begin
				st_next.ph_cnt = st_reg.ph_cnt + CNT_ONE;
				if (st_reg.ph_cnt == hi_lim) begin
					st_next.ph_cnt = '0;
					st_next.fsm    = RCF_ST_LOW; // R1
				end
			end
			RCF_ST_LOW: begin
				st_next.ph_cnt = st_reg.ph_cnt + CNT_ONE;
				if (st_reg.ph_cnt == lo_lim) begin
					st_next.ph_cnt  = '0;
					st_next.seg_cnt = '0;
					st_next.seg_idx = '0;
					st_next.row_adv = 1'h1;
					st_next.fsm     = RCF_ST_HIGH; // R1
					if (i_mem_end && st_reg.mode != RCF_MODE_CUE) begin
						hit_ovf = 1'h1; // R9
					end
				end
			end
			default: begin
				st_next.fsm = RCF_ST_IDLE;
			end
		endcase

		// Marker slots tile the whole row, high and low parts alike
		if (st_reg.fsm == RCF_ST_HIGH || st_reg.fsm == RCF_ST_LOW) begin
			if (!st_next.row_adv) begin
				st_next.seg_cnt = st_reg.seg_cnt + CNT_ONE;
				if (st_reg.seg_cnt == seg_lim) begin
					st_next.seg_cnt = '0;
					st_next.seg_idx = st_reg.seg_idx + rcf_slot_t'(1); // R11
				end
			end
			if (st_reg.seg_cnt == seg_lim && st_reg.mode == RCF_MODE_PLAY &&
			    i_row_eom_marks[st_reg.seg_idx]) begin
				hit_eom = 1'h1; // R10 R11
			end
		end

		// Read-status reports and clears the flags
		if (i_read_interrupt_status_cmd) begin
			st_next.status.valid = 1'h1; // R8
			st_next.status.ovf   = st_reg.ovf;
			st_next.status.end_of_message_flag   = st_reg.end_of_message_flag;
			st_next.ovf          = 1'h0;
			st_next.end_of_message_flag          = 1'h0;
		end

		// Host stop ends the operation without an interrupt
		if (st_reg.fsm != RCF_ST_IDLE && i_op.stop) begin
			st_next.fsm     = RCF_ST_IDLE;
			st_next.op_done = 1'h1;
		end

		// Flagged termination; a new event outranks a same-cycle clear
		if (hit_ovf || hit_eom) begin
			st_next.ovf      = st_next.ovf | hit_ovf; // R9
			st_next.end_of_message_flag      = st_next.end_of_message_flag | hit_eom; // R10
			st_next.fsm      = RCF_ST_IDLE;
			st_next.op_done  = 1'h1;
		end

		if (ss_fall) begin
			st_next.int_pend = 1'h0; // R7
		end
		if (hit_ovf || hit_eom) begin
			st_next.int_pend = 1'h1; // R5 R6
		end

		// Open-drain: data low, enable pulls the wire
		st_next.rac_o  = 1'h0;
		st_next.rac_oe = (st_next.fsm == RCF_ST_LOW); // R1 R2 R3
		st_next.int_o  = 1'h0;
		st_next.int_oe = st_next.int_pend;            // R5
		st_next.busy   = (st_next.fsm != RCF_ST_IDLE);
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_reg         <= '0;
			st_reg.fsm     <= RCF_ST_IDLE;
			st_reg.mode    <= RCF_MODE_REC;
			st_reg.ss_prev <= RCF_SS_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_row_boundary_clock_o  = st_reg.rac_o;
	assign o_row_boundary_clock_oe = st_reg.rac_oe;
	assign o_int_o                 = st_reg.int_o;
	assign o_int_oe                = st_reg.int_oe;
	assign o_status                = st_reg.status;
	assign o_op_done               = st_reg.op_done;
	assign o_row_adv               = st_reg.row_adv;
	assign o_busy                  = st_reg.busy;

	////////////////////////////////////////////////////////////////////////////////
	// Checks; run counters measure the low phase on the pin, the high and load phases from the state
	rcf_cnt_t lo_run;
	rcf_cnt_t hi_run;
	rcf_cnt_t ld_run;
	logic     oe_d;
	logic     hi_d;
	logic     ld_d;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lo_run <= '0;
			hi_run <= '0;
			ld_run <= '0;
			oe_d   <= 1'h0;
			hi_d   <= 1'h0;
			ld_d   <= 1'h0;
		end else begin
			oe_d <= o_row_boundary_clock_oe;
			hi_d <= (st_reg.fsm == RCF_ST_HIGH);
			ld_d <= (st_reg.fsm == RCF_ST_LOAD);
			if (o_row_boundary_clock_oe) begin
				lo_run <= oe_d ? lo_run + CNT_ONE : CNT_ONE;
			end
			if (st_reg.fsm == RCF_ST_HIGH) begin
				hi_run <= hi_d ? hi_run + CNT_ONE : CNT_ONE;
			end
			if (st_reg.fsm == RCF_ST_LOAD) begin
				ld_run <= ld_d ? ld_run + CNT_ONE : CNT_ONE;
			end
		end
	end

	a_rac_low_time: assert property ( // R2
		@(posedge i_clk) disable iff (!i_arst_n)
		o_row_adv |-> lo_run == lo_lim + CNT_ONE
	) else $error("row clock low phase has the wrong length");

	a_rac_high_time: assert property ( // R1
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(o_row_boundary_clock_oe) |-> hi_run == hi_lim + CNT_ONE
	) else $error("row clock high phase has the wrong length");

	a_cue_low_time: assert property ( // R3
		@(posedge i_clk) disable iff (!i_arst_n)
		(o_row_adv && st_reg.mode == RCF_MODE_CUE) |-> lo_run == CUE_LO_L + CNT_ONE
	) else $error("cueing row low phase has the wrong length");

	a_load_extra_high: assert property ( // R4
		@(posedge i_clk) disable iff (!i_arst_n)
		(st_reg.fsm == RCF_ST_HIGH && $past(st_reg.fsm) == RCF_ST_LOAD) |->
			ld_run == ROW_LO_L + CNT_ONE && !o_row_boundary_clock_oe
	) else $error("record start did not hold the row clock high one low interval");

	a_int_on_event: assert property ( // R6
		@(posedge i_clk) disable iff (!i_arst_n)
		(hit_ovf || hit_eom) |=> o_int_oe && o_op_done && st_reg.fsm == RCF_ST_IDLE
	) else $error("flagged termination did not raise the interrupt");

	a_int_held: assert property ( // R5
		@(posedge i_clk) disable iff (!i_arst_n)
		(o_int_oe && !ss_fall) |=> o_int_oe
	) else $error("interrupt released without a new serial cycle");

	a_int_clear: assert property ( // R7
		@(posedge i_clk) disable iff (!i_arst_n)
		(ss_fall && !hit_ovf && !hit_eom) |=> !o_int_oe
	) else $error("interrupt not released at start of serial cycle");

	a_read_interrupt_status_cmd_report: assert property ( // R8
		@(posedge i_clk) disable iff (!i_arst_n)
		i_read_interrupt_status_cmd |=>
			o_status.valid && o_status.ovf == $past(st_reg.ovf) && o_status.end_of_message_flag == $past(st_reg.end_of_message_flag)
	) else $error("read status did not report the flags");

	a_ovf_at_end: assert property ( // R9
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(st_reg.ovf) |-> o_row_adv && $past(i_mem_end) && $past(st_reg.mode) != RCF_MODE_CUE
	) else $error("overflow flag set away from end of array");

	a_eom_play_only: assert property ( // R10
		@(posedge i_clk) disable iff (!i_arst_n)
		$rose(st_reg.end_of_message_flag) |-> $past(st_reg.mode) == RCF_MODE_PLAY &&
			$past(i_row_eom_marks[st_reg.seg_idx])
	) else $error("end-of-message flag set outside playback marker");

endmodule

// File: inc/rcf_pkg.sv
/*
 * Shared constants and types for the row boundary clock and message flag block.
 * Assumes a single 40 MHz system clock; all timing counts derive from it here.
 */
package rcf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock rate
	localparam real RCF_CLK_MHZ = 40.0;

	////////////////////////////////////////////////////////////////////////////////
	// Row timing at the 8 kHz sample rate, as printed
	localparam real RCF_ROW_HIGH_MS = 175.0;
	localparam real RCF_ROW_LOW_MS  = 25.0;
	localparam real RCF_CUE_HIGH_US = 109.37;
	localparam real RCF_CUE_LOW_US  = 15.63;

	// Least times, rounded up to whole clock cycles
	localparam int unsigned RCF_ROW_HIGH_CYC = int'($ceil(RCF_ROW_HIGH_MS * 1000.0 * RCF_CLK_MHZ));
	localparam int unsigned RCF_ROW_LOW_CYC  = int'($ceil(RCF_ROW_LOW_MS * 1000.0 * RCF_CLK_MHZ));
	localparam int unsigned RCF_CUE_HIGH_CYC = int'($ceil(RCF_CUE_HIGH_US * RCF_CLK_MHZ));
	localparam int unsigned RCF_CUE_LOW_CYC  = int'($ceil(RCF_CUE_LOW_US * RCF_CLK_MHZ));

	////////////////////////////////////////////////////////////////////////////////
	// Widths and layout
	localparam int unsigned RCF_CNT_W     = 24;
	localparam int unsigned RCF_EOM_SLOTS = 8;
	localparam int unsigned RCF_SLOT_W    = 3;

	typedef logic [RCF_CNT_W-1:0]     rcf_cnt_t;
	typedef logic [RCF_SLOT_W-1:0]    rcf_slot_t;
	typedef logic [RCF_EOM_SLOTS-1:0] rcf_marks_t;

	////////////////////////////////////////////////////////////////////////////////
	// Operation modes and row clock states
	typedef enum logic [1:0] {
		RCF_MODE_REC  = 2'h0,
		RCF_MODE_PLAY = 2'h1,
		RCF_MODE_CUE  = 2'h2
	} rcf_mode_e;

	typedef enum logic [3:0] {
		RCF_ST_IDLE = 4'h1,
		RCF_ST_LOAD = 4'h2,
		RCF_ST_HIGH = 4'h4,
		RCF_ST_LOW  = 4'h8
	} rcf_rac_e;

	////////////////////////////////////////////////////////////////////////////////
	// Carriers
	typedef struct packed {
		logic      start;
		logic      stop;
		rcf_mode_e mode;
	} rcf_op_s;

	typedef struct packed {
		logic valid;
		logic ovf;
		logic end_of_message_flag;
	} rcf_status_s;

	localparam logic RCF_SS_IDLE = 1'h1;

endpackage

// File: verif/rcf_host_model.sv
/*
 * Host side: pull-ups on both open-drain lines, slave select and status read.
 * Assumes request pulses come from the bench on the rising clock edge.
 */
`timescale 1ns/1ps
module rcf_host_model (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// Open-drain pins of the device
	input  wire logic i_rac_o,
	input  wire logic i_rac_oe,
	input  wire logic i_int_o,
	input  wire logic i_int_oe,
	// Bench requests
	input  wire logic i_clear_req,
	input  wire logic i_read_req,
	// Resolved lines and host outputs
	output logic      o_rac_line,
	output logic      o_int_line,
	output logic      o_ss_n,
	output logic      o_read_cmd
);
	int sel_cnt;

	// Pull-ups: a released line reads high
	assign o_rac_line = i_rac_oe ? i_rac_o : 1'h1;
	assign o_int_line = i_int_oe ? i_int_o : 1'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Select held low several cycles so the device filter sees it
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sel_cnt    <= 0;
			o_ss_n     <= 1'h1;
			o_read_cmd <= 1'h0;
		end else begin
			o_read_cmd <= i_read_req;
			sel_cnt    <= i_clear_req ? 6 : (sel_cnt > 0 ? sel_cnt - 1 : 0);
			o_ss_n     <= !(i_clear_req || sel_cnt > 1);
		end
	end
endmodule

// File: verif/rcf_top_tb.sv
/*
 * Self-checking bench for the row clock and message flag block.
 * Assumes shortened row counts; the host model resolves the open-drain lines.
 */
`timescale 1ns/1ps
module rcf_top_tb;
	import rcf_pkg::*;
	localparam int H = 70;
	localparam int L = 10;
	localparam int CH = 35;
	localparam int CL = 5;
	localparam int S = (H + L) / 8;

	logic        i_clk = 1'h0;
	logic        i_arst_n = 1'h0;
	rcf_op_s     op = '{1'h0, 1'h0, RCF_MODE_PLAY};
	logic        mem_end = 1'h0;
	rcf_marks_t  marks = 8'h00;
	logic        clear_req = 1'h0;
	logic        read_req = 1'h0;
	logic        ss_n, rd_cmd, rac_o, rac_oe, int_o, int_oe, rac_line, int_line;
	logic        op_done, row_adv, busy;
	rcf_status_s status;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          exp_ovf = 0;
	int          exp_eom = 0;
	int          n;
	logic [15:0] rnd = 16'hc999;

	rcf_top #(.P_ROW_HIGH_CYC(H), .P_ROW_LOW_CYC(L), .P_CUE_HIGH_CYC(CH), .P_CUE_LOW_CYC(CL))
	i_rcf_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_op(op), .i_mem_end(mem_end),
		.i_row_eom_marks(marks), .i_ss_n(ss_n), .i_read_interrupt_status_cmd(rd_cmd),
		.o_row_boundary_clock_o(rac_o), .o_row_boundary_clock_oe(rac_oe), .o_int_o(int_o),
		.o_int_oe(int_oe), .o_status(status), .o_op_done(op_done), .o_row_adv(row_adv),
		.o_busy(busy));

	rcf_host_model i_rcf_host_model (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_rac_o(rac_o),
		.i_rac_oe(rac_oe), .i_int_o(int_o), .i_int_oe(int_oe), .i_clear_req(clear_req),
		.i_read_req(read_req), .o_rac_line(rac_line), .o_int_line(int_line),
		.o_ss_n(ss_n), .o_read_cmd(rd_cmd));

	initial begin
		forever #12.5 i_clk = !i_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic pick(input int w);
		case (w)
			0: return rac_line;
			1: return busy;
			2: return op_done;
			3: return int_line;
			default: return status.valid;
		endcase
	endfunction

	task automatic cmp_len(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	// Counts edges until the chosen signal shows the level; bounded
	task automatic wait_on(input int w, input logic lvl, output int cnt);
		cnt = 0;
		do begin
			@(posedge i_clk);
			#1;
			cnt++;
		end while (pick(w) !== lvl && cnt < 2000);
		if (cnt >= 2000) begin
			n_fail++;
			$display("ERROR at %0t: wait limit got %h exp %h", $time, pick(w), lvl);
		end
	endtask

	task automatic op_start(input rcf_mode_e m);
		wait_on(1, 1'h0, n);
		@(posedge i_clk);
		op.start <= 1'h1;
		op.mode  <= m;
		@(posedge i_clk);
		op.start <= 1'h0;
		#1;
	endtask

	task automatic op_stop();
		@(posedge i_clk);
		op.stop <= 1'h1;
		@(posedge i_clk);
		op.stop <= 1'h0;
		wait_on(1, 1'h0, n);
	endtask

	task automatic meas_row(input int eh, input int el);
		wait_on(0, 1'h0, n);
		cmp_len(n, eh);
		wait_on(0, 1'h1, n);
		cmp_len(n, el);
		cmp_bit(row_adv, 1'h1);
	endtask

	// Flags expected from the bench model, which a read then clears
	task automatic read_chk();
		@(posedge i_clk);
		read_req <= 1'h1;
		@(posedge i_clk);
		read_req <= 1'h0;
		wait_on(4, 1'h1, n);
		cmp_len(n, 1);
		cmp_bit(status.ovf, exp_ovf[0]);
		cmp_bit(status.end_of_message_flag, exp_eom[0]);
		exp_ovf = 0;
		exp_eom = 0;
	endtask

	task automatic clear_int();
		@(posedge i_clk);
		clear_req <= 1'h1;
		@(posedge i_clk);
		clear_req <= 1'h0;
		wait_on(3, 1'h1, n);
		// Three sync stages, agreement, then edge detect into the interrupt register
		cmp_len(n, 5);
		cmp_bit(int_line, 1'h1);
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Ceiling well above the roughly one thousand cycles the tests need
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_fail++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge i_clk);
		i_arst_n <= 1'h1;
		repeat (6) @(posedge i_clk);
		op_start(RCF_MODE_PLAY);
		cmp_bit(busy, 1'h1);
		meas_row(H, L);
		meas_row(H, L);
		op_stop();
		cmp_bit(int_line, 1'h1);
		read_chk();
		$display("test play done");
		op_start(RCF_MODE_REC);
		meas_row(L + H, L);
		mem_end <= 1'h1;
		meas_row(H, L);
		cmp_bit(op_done, 1'h1);
		exp_ovf = 1;
		repeat (2) @(posedge i_clk);
		mem_end <= 1'h0;
		#1;
		cmp_bit(busy, 1'h0);
		for (int i = 0; i < 20; i++) begin
			@(posedge i_clk);
			#1;
			cmp_bit(int_line, 1'h0);
		end
		read_chk();
		read_chk();
		clear_int();
		$display("test record overflow done");
		marks <= 8'hff;
		op_start(RCF_MODE_CUE);
		meas_row(CH, CL);
		meas_row(CH, CL);
		op_stop();
		cmp_bit(int_line, 1'h1);
		read_chk();
		$display("test cue done");
		for (int k = 0; k < 8; k++) begin
			rnd = lfsr(rnd);
			marks <= rcf_marks_t'((rnd[7:0] << k) | (8'h01 << k));
			op_start(RCF_MODE_PLAY);
			wait_on(2, 1'h1, n);
			cmp_len(n, (k + 1) * S);
			exp_eom = 1;
			#1;
			cmp_bit(int_line, 1'h0);
			read_chk();
			clear_int();
		end
		marks <= 8'h00;
		$display("test marker slots done");
		give_verdict();
	end
endmodule
